/* cra_access.sv */
// Purpose: serial-bus access to the 96-byte call ram and the 48-byte config rom
// Assumes: scl/sda are open drain, sampled by core_clk through three flops
// Notes: rom writes are gathered into a row buffer and committed on the sixth byte
`timescale 1ns/100ps
`include "cra_regs.svh"

// simple synchronous fifo with valid/ready on both sides
module cra_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage, no reset needed on the data words
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

module cra_access #(
  parameter logic [6:0] DEV_ADDR = 7'h20,
  parameter int PROG_CYCLES = `CRA_PROG_TIME_NS / `CRA_CLK_PERIOD_NS
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire cra_pkg::cra_call_s call_in,
  output logic call_ready,
  input wire logic receiver_active_flag,
  input wire logic prog_enable,
  input wire logic status_read,
  output logic data_pending,
  output logic ptr_equal,
  output logic ram_irq,
  output logic prog_busy,
  output cra_pkg::cra_cfg_s special_function_config
);
  import cra_pkg::*;

  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic scl_f_q;
  logic sda_f_q;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  cra_state_e state_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] sub_q;
  logic rw_q;
  logic mack_q;
  logic rd_fx_q;
  logic wr_fx_q;
  logic stretch_q;
  logic [7:0] ram [`CRA_RAM_DEPTH];
  logic [7:0] rom [`CRA_ROM_BYTES];
  logic [7:0] rowbuf_q [`CRA_ROM_COLS];
  logic [6:0] wptr_q;
  logic [6:0] wptr_d;
  logic [6:0] rptr_q;
  logic [6:0] rptr_d;
  logic [2:0] col_q;
  logic [2:0] row_q;
  logic [5:0] rom_idx;
  logic [7:0] rd_val;
  logic pend_q;
  logic eq_q;
  logic [20:0] busy_q;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic ram_store;
  logic ram_read;
  logic rom_access;
  logic rom_write;
  logic commit;

  // open drain: we only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = stretch_q;
  assign prog_busy = (busy_q != '0);

  // three-flop sampling; a level counts once the 2nd and 3rd flops agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_in};
      sda_s_q <= {sda_s_q[1:0], sda_in};
      scl_f_q <= scl_d;
      sda_f_q <= sda_d;
    end
  end

  assign scl_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
  assign sda_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
  assign scl_rise = scl_d && !scl_f_q;
  assign scl_fall = !scl_d && scl_f_q;
  // start/stop: sda moving while scl stays high
  assign bus_start = scl_f_q && scl_d && sda_f_q && !sda_d;
  assign bus_stop = scl_f_q && scl_d && !sda_f_q && sda_d;

  // read mux for the addressed register; unused top bits read zero
  assign rom_idx = 6'(row_q * `CRA_ROM_COLS) + {3'h0, col_q};
  always_comb begin
    unique case (sub_q)
      `CRA_OFS_WPTR: rd_val = {1'b0, wptr_q};
      `CRA_OFS_EEPTR: rd_val = {2'h0, row_q, col_q};
      `CRA_OFS_RPTR: rd_val = {1'b0, rptr_q};
      `CRA_OFS_RAMDAT: rd_val = ram[rptr_q];
      `CRA_OFS_EEDAT: rd_val = rom[rom_idx];
      default: rd_val = `CRA_UNMAPPED_RD;
    endcase
  end

  // serial slave: byte framing, acks, and one-cycle read/write effects
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= CRA_IDLE;
      bit_q <= '0;
      sh_q <= '0;
      sub_q <= '0;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      sda_oe <= 1'b0;
      rd_fx_q <= 1'b0;
      wr_fx_q <= 1'b0;
    end else begin
      rd_fx_q <= 1'b0;
      wr_fx_q <= 1'b0;
      if (bus_start) begin
        state_q <= CRA_ADDR;
        bit_q <= '0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state_q <= CRA_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (state_q == CRA_RACK) begin
          mack_q <= !sda_f_q;
        end else if (state_q == CRA_ADDR || state_q == CRA_SUB || state_q == CRA_WDAT) begin
          sh_q <= {sh_q[6:0], sda_f_q};
          bit_q <= bit_q + 4'h1;
        end
      end else if (scl_fall) begin
        unique case (state_q)
          CRA_IDLE: begin
            sda_oe <= 1'b0;
          end
          CRA_ADDR: begin
            if (bit_q == `CRA_BITS_PER_BYTE) begin
              if (sh_q[7:1] == DEV_ADDR) begin
                state_q <= CRA_AACK;
                rw_q <= sh_q[0];
                sda_oe <= 1'b1;
              end else begin
                state_q <= CRA_IDLE;
              end
            end
          end
          CRA_AACK, CRA_RACK: begin
            bit_q <= '0;
            if (state_q == CRA_RACK && !mack_q) begin
              state_q <= CRA_IDLE;
              sda_oe <= 1'b0;
            end else if (rw_q) begin
              // fetch happens here, so a byte is consumed only when it goes out
              state_q <= CRA_RDAT;
              sh_q <= rd_val;
              sda_oe <= !rd_val[7];
              rd_fx_q <= 1'b1;
            end else begin
              state_q <= CRA_SUB;
              sda_oe <= 1'b0;
            end
          end
          CRA_SUB: begin
            if (bit_q == `CRA_BITS_PER_BYTE) begin
              state_q <= CRA_SACK;
              sub_q <= sh_q;
              sda_oe <= 1'b1;
            end
          end
          CRA_SACK, CRA_WACK: begin
            state_q <= CRA_WDAT;
            bit_q <= '0;
            sda_oe <= 1'b0;
          end
          CRA_WDAT: begin
            if (bit_q == `CRA_BITS_PER_BYTE) begin
              state_q <= CRA_WACK;
              sda_oe <= 1'b1;
              wr_fx_q <= 1'b1;
            end
          end
          CRA_RDAT: begin
            if (bit_q == `CRA_LAST_BIT) begin
              state_q <= CRA_RACK;
              sda_oe <= 1'b0;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_oe <= !sh_q[6];
              bit_q <= bit_q + 4'h1;
            end
          end
          default: begin
            state_q <= CRA_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // clock stretch: a transfer begun during the programming pause waits
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stretch_q <= 1'b0;
    end else if (!prog_busy) begin
      stretch_q <= 1'b0;
    end else if (bus_start) begin
      stretch_q <= 1'b1;
    end
  end

  // decoder bytes queue here; the ram port stalls the drain during a host fetch
  cra_fifo #(
    .W(8),
    .D(`CRA_FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .in_valid(call_in.valid),
    .in_ready(call_ready),
    .in_data(call_in.data),
    .out_valid(fifo_valid),
    .out_ready(!ram_read),
    .out_data(fifo_data)
  );

  assign ram_read = rd_fx_q && (sub_q == `CRA_OFS_RAMDAT);
  assign ram_store = fifo_valid && !ram_read;

  // next pointer values, wrapping at the last ram location
  always_comb begin
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    if (ram_store) begin
      wptr_d = (wptr_q == `CRA_RAM_LAST) ? `CRA_PTR_ZERO : wptr_q + 7'h01;
    end
    if (wr_fx_q && sub_q == `CRA_OFS_RPTR) begin
      rptr_d = sh_q[6:0];
    end else if (ram_read) begin
      rptr_d = (rptr_q == `CRA_RAM_LAST) ? `CRA_PTR_ZERO : rptr_q + 7'h01;
    end
  end

  // call ram storage
  always_ff @(posedge core_clk) begin
    if (ram_store) begin
      ram[wptr_q] <= fifo_data;
    end
  end

  // ram pointers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr_q <= `CRA_PTR_ZERO;
      rptr_q <= `CRA_PTR_ZERO;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
    end
  end

  // pending and equal flags; an equality event wins over a status read
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
      eq_q <= 1'b0;
    end else begin
      // only a moving read pointer may clear it, so a full ram stays pending
      if (wptr_d != rptr_d) begin
        pend_q <= 1'b1;
      end else if (rptr_d != rptr_q) begin
        pend_q <= 1'b0;
      end
      if (wptr_d == rptr_d && wptr_q != rptr_q) begin
        eq_q <= 1'b1;
      end else if (status_read) begin
        eq_q <= 1'b0;
      end
    end
  end

  assign data_pending = pend_q;
  assign ptr_equal = eq_q;
  assign ram_irq = (pend_q && !receiver_active_flag) || eq_q;

  // rom data port decode
  assign rom_access = (rd_fx_q || wr_fx_q) && (sub_q == `CRA_OFS_EEDAT);
  assign rom_write = wr_fx_q && (sub_q == `CRA_OFS_EEDAT) && prog_enable && !prog_busy;
  assign commit = rom_write && (col_q == `CRA_COL_LAST);

  // rom address pointer: column and row counters in series
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      col_q <= '0;
      row_q <= '0;
    end else if (wr_fx_q && sub_q == `CRA_OFS_EEPTR) begin
      row_q <= sh_q[`CRA_ROW_HI:`CRA_ROW_LO];
      col_q <= (sh_q[`CRA_COL_HI:`CRA_COL_LO] > `CRA_COL_LAST) ? 3'h0 :
               sh_q[`CRA_COL_HI:`CRA_COL_LO];
    end else if (rom_access) begin
      if (col_q == `CRA_COL_LAST) begin
        col_q <= 3'h0;
        row_q <= (row_q == `CRA_ROW_LAST) ? 3'h0 : row_q + 3'h1;
      end else begin
        col_q <= col_q + 3'h1;
      end
    end
  end

  // row buffer: bytes not sent before the sixth commit as zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `CRA_ROM_COLS; i++) begin
        rowbuf_q[i] <= 8'h00;
      end
    end else if (bus_stop || commit) begin
      for (int i = 0; i < `CRA_ROM_COLS; i++) begin
        rowbuf_q[i] <= 8'h00;
      end
    end else if (rom_write) begin
      rowbuf_q[col_q] <= sh_q;
    end
  end

  // rom array; cleared at reset since this model holds no charge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `CRA_ROM_BYTES; i++) begin
        rom[i] <= 8'h00;
      end
    end else if (commit) begin
      for (int c = 0; c < `CRA_ROM_COLS - 1; c++) begin
        rom[6'(row_q * `CRA_ROM_COLS + c)] <= rowbuf_q[c];
      end
      rom[rom_idx] <= sh_q;
    end
  end

  // programming pause counter
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= '0;
    end else if (commit) begin
      busy_q <= 21'(PROG_CYCLES);
    end else if (busy_q != '0) begin
      busy_q <= busy_q - 21'h1;
    end
  end

  // configuration decode; short cycles ignore the batch msb
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      special_function_config <= '0;
    end else begin
      special_function_config.alt_protocol <= rom[0][0];
      special_function_config.long_cycle <= rom[0][1];
      special_function_config.batch_number <= {rom[0][5] & rom[0][1], rom[0][4:2]};
      special_function_config.continuous_decode <= rom[0][6];
      special_function_config.invert_data <= rom[0][7];
      special_function_config.rx_estab_sel <= rom[1][1:0];
      special_function_config.osc_estab_sel <= rom[1][3:2];
      special_function_config.bit_rate_sel <= rom[1][5:4];
      special_function_config.synth_enable <= rom[1][6];
      special_function_config.converter_enable <= rom[1][7];
    end
  end
endmodule

/* cra_access_checker.sv */
// Purpose: port-level checks for cra_access
// Assumes: one clock domain, reset asynchronous active low
// Notes: pause length is counted in helper logic
`timescale 1ns/100ps
module cra_access_checker #(
  parameter int PROG_CYCLES = 1875000
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic scl_oe,
  input wire logic receiver_active_flag,
  input wire logic prog_enable,
  input wire logic status_read,
  input wire logic data_pending,
  input wire logic ptr_equal,
  input wire logic ram_irq,
  input wire logic prog_busy,
  input wire cra_pkg::cra_cfg_s special_function_config
);
  import cra_pkg::*;
  int busy_cnt_q;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // length of the running pause, so its end can be tied to the parameter
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt_q <= 0;
    end else if (prog_busy) begin
      busy_cnt_q <= busy_cnt_q + 1;
    end else begin
      busy_cnt_q <= 0;
    end
  end

  // programming pause and clock stretching
  a_busy_length: assert property ($fell(prog_busy) |-> busy_cnt_q == PROG_CYCLES)
    else $error("programming pause has the wrong length");
  a_busy_enabled: assert property ($rose(prog_busy) |-> prog_enable)
    else $error("programming started without enable");
  a_stretch_cause: assert property ($rose(scl_oe) |-> $past(prog_busy))
    else $error("scl held low outside a pause");
  a_scl_release: assert property ($fell(prog_busy) |-> ##[0:4] !scl_oe)
    else $error("scl still held after the pause");
  // ram status flags and interrupt
  a_irq_cause: assert property (ram_irq == (ptr_equal || (data_pending && !receiver_active_flag)))
    else $error("interrupt does not follow its causes");
  a_equal_sticky: assert property (ptr_equal && !status_read |=> ptr_equal)
    else $error("equal flag cleared without a status read");
  a_pending_empty: assert property ($fell(data_pending) |-> ##[0:2] ptr_equal)
    else $error("pending flag cleared while pointers differ");
  // decoded configuration only moves with a committed row
  a_cfg_protect: assert property (!$stable(special_function_config) |-> prog_enable)
    else $error("configuration changed while protected");
  a_cfg_commit: assert property (!$stable(special_function_config) |-> ##[0:2] prog_busy)
    else $error("configuration changed without a programming cycle");
endmodule

bind cra_access cra_access_checker #(.PROG_CYCLES(PROG_CYCLES)) i_cra_access_checker (
  .core_clk(core_clk), .rst_b(rst_b), .scl_oe(scl_oe), .prog_busy(prog_busy),
  .receiver_active_flag(receiver_active_flag), .prog_enable(prog_enable),
  .status_read(status_read), .data_pending(data_pending), .ptr_equal(ptr_equal),
  .ram_irq(ram_irq), .special_function_config(special_function_config));

/* cra_access_tb.sv */
// Purpose: self-checking bench for cra_access
// Assumes: host model on the serial pins, decoder bytes driven directly
// Notes: programming pause shortened to PROG cycles
`timescale 1ns/100ps
module cra_access_tb;
  import cra_pkg::*;
  localparam int PROG = 200;
  localparam logic [7:0] AW = 8'h40;
  localparam logic [7:0] AR = 8'h41;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic scl_in, sda_in, scl_oe, sda_oe, call_ready, data_pending, ptr_equal, ram_irq, prog_busy;
  cra_call_s call_in = '0;
  logic receiver_active_flag = 1'b0;
  logic prog_enable = 1'b0;
  logic status_read = 1'b0;
  cra_cfg_s cfg;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic stretched = 1'b0;
  logic ack;
  logic [7:0] rbuf [96];
  logic [7:0] img [96];
  logic [7:0] cq [$];
  logic [7:0] zero6 [$] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] blk [$] = '{8'h5A, 8'hC3, 8'h01, 8'hFE, 8'h80, 8'h7F};
  // sub-address, value written, value read back
  logic [23:0] rows [6] = '{24'h08_85_05, 24'h07_D3_13, 24'h07_2E_28, 24'h07_0F_08,
    24'h06_33_00, 24'h0B_12_FF};

  cra_access #(.DEV_ADDR(7'h20), .PROG_CYCLES(PROG)) i_cra_access (
    .core_clk(core_clk), .rst_b(rst_b), .scl_in(scl_in), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe), .call_in(call_in), .call_ready(call_ready),
    .receiver_active_flag(receiver_active_flag), .prog_enable(prog_enable),
    .status_read(status_read), .data_pending(data_pending), .ptr_equal(ptr_equal),
    .ram_irq(ram_irq), .prog_busy(prog_busy), .special_function_config(cfg));
  cra_host i_cra_host (.core_clk(core_clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .scl_in(scl_in), .sda_in(sda_in));

  always #2 core_clk = !core_clk;
  // remember any stretch seen on the clock line
  always @(posedge core_clk) if (scl_oe === 1'b1) stretched <= 1'b1;

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // every data byte goes to the same sub-address
  task automatic wr(input logic [7:0] sub, input logic [7:0] q [$]);
    i_cra_host.start();
    i_cra_host.wb(AW, ack);
    i_cra_host.wb(sub, ack);
    foreach (q[i]) i_cra_host.wb(q[i], ack);
    i_cra_host.stop();
  endtask
  // last byte is refused so no extra fetch happens
  task automatic rd(input logic [7:0] sub, input int n);
    i_cra_host.start();
    i_cra_host.wb(AW, ack);
    i_cra_host.wb(sub, ack);
    i_cra_host.start();
    i_cra_host.wb(AR, ack);
    for (int i = 0; i < n; i++) i_cra_host.rb(i < n - 1, rbuf[i]);
    i_cra_host.stop();
  endtask
  task automatic rom_chk(input logic [7:0] ptr, input logic [7:0] q [$]);
    wr(8'h07, '{ptr});
    rd(8'h0A, 6);
    foreach (q[i]) chk("rom byte", 16'(q[i]), 16'(rbuf[i]));
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #300000;
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    chk("idle outputs", 16'h0001,
      16'({data_pending, ptr_equal, ram_irq, prog_busy, scl_oe, sda_oe, call_ready}));
    foreach (rows[i]) begin
      wr(rows[i][23:16], '{rows[i][15:8]});
      rd(rows[i][23:16], 1);
      chk("register", 16'(rows[i][7:0]), 16'(rbuf[0]));
    end
    chk("address ack", 16'h0001, 16'(ack));
    // fill the whole call ram from the decoder side
    wr(8'h08, '{8'h00});
    status_read = 1'b1;
    tick();
    status_read = 1'b0;
    tick();
    chk("flags before fill", 16'h0000, 16'({data_pending, ptr_equal}));
    for (int i = 0; i < 96; i++) begin
      img[i] = 8'(i * 7 + 3);
      call_in = {1'b1, img[i]};
      while (call_ready !== 1'b1) tick();
      tick();
    end
    call_in = '0;
    rd(8'h06, 1);
    chk("write pointer", 16'h0000, 16'(rbuf[0]));
    chk("full flags", 16'h0007, 16'({data_pending, ptr_equal, ram_irq}));
    receiver_active_flag = 1'b1;
    status_read = 1'b1;
    tick();
    status_read = 1'b0;
    tick();
    chk("status cleared", 16'h0000, 16'({ptr_equal, ram_irq}));
    receiver_active_flag = 1'b0;
    tick();
    chk("pending irq", 16'h0001, 16'(ram_irq));
    // read across the top of the ram until it is empty
    wr(8'h08, '{8'hDE});
    rd(8'h09, 2);
    chk("ram data", 16'(img[94]), 16'(rbuf[0]));
    chk("ram data", 16'(img[95]), 16'(rbuf[1]));
    rd(8'h08, 1);
    chk("read pointer", 16'h0000, 16'(rbuf[0]));
    chk("empty flags", 16'h0001, 16'({data_pending, ptr_equal}));
    // rom block without enable is dropped but the pointer moves
    wr(8'h07, '{8'h28});
    wr(8'h0A, blk);
    rd(8'h07, 1);
    chk("rom pointer", 16'h0030, 16'(rbuf[0]));
    rom_chk(8'h28, zero6);
    prog_enable = 1'b1;
    wr(8'h07, '{8'h28});
    wr(8'h0A, blk);
    stretched = 1'b0;
    rd(8'h07, 1);
    chk("rom pointer", 16'h0030, 16'(rbuf[0]));
    chk("scl held", 16'h0001, 16'(stretched));
    rom_chk(8'h28, blk);
    wr(8'h07, '{8'h28});
    wr(8'h0A, '{8'hEE, 8'hEE, 8'hEE});
    rom_chk(8'h28, blk);
    // every code of each configuration field except the four-bit batch number
    for (int k = 0; k < 4; k++) begin
      cq = '{8'(8'hA4 + k * 8'h35), {4{k[1:0]}}, 8'h00, 8'h00, 8'h11, 8'h22};
      wr(8'h07, '{8'h00});
      wr(8'h0A, cq);
      tick();
      tick();
      chk("config", 16'({cq[0][0], cq[0][1], cq[0][5] & cq[0][1], cq[0][4:2], cq[0][6],
        cq[0][7], cq[1][1:0],
        cq[1][3:2], cq[1][5:4], cq[1][6], cq[1][7]}), 16'(cfg));
    end
    rom_chk(8'h00, cq);
    prog_enable = 1'b0;
    wr(8'h07, '{8'h38});
    rd(8'h0A, 6);
    rd(8'h07, 1);
    chk("row wrap", 16'h0000, 16'(rbuf[0]));
    summarize();
  end
endmodule

/* cra_host.sv */
// Purpose: serial bus master model facing cra_access
// Assumes: open-drain lines with pull-ups, 64 ns bit period
// Notes: waits out clock stretching under a bound
`timescale 1ns/100ps
module cra_host (
  input wire logic core_clk,
  input wire logic scl_oe,
  input wire logic sda_oe,
  output logic scl_in,
  output logic sda_in
);
  logic scl_lo = 1'b0;
  logic sda_lo = 1'b0;
  // pull-ups: a released line reads high
  assign scl_in = !(scl_lo || scl_oe);
  assign sda_in = !(sda_lo || sda_oe);

  // wait n core cycles, then step just past the edge
  task automatic hp(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // release scl; a device in its pause holds it low, so wait for it
  task automatic rise();
    int k;
    k = 0;
    scl_lo = 1'b0;
    while (!scl_in && k < 4000) begin
      hp(1);
      k++;
    end
    hp(8);
  endtask
  // sda moves only mid-way through scl low, never while scl is high
  task automatic wbit(input logic b, output logic r);
    hp(4);
    sda_lo = !b;
    hp(4);
    rise();
    r = sda_in;
    scl_lo = 1'b1;
  endtask
  // start and stop differ only in the sda direction while scl is high
  task automatic cond(input logic a);
    hp(4);
    sda_lo = a;
    hp(4);
    rise();
    sda_lo = !a;
    hp(8);
  endtask
  task automatic start();
    cond(1'b0);
    scl_lo = 1'b1;
  endtask
  task automatic stop();
    cond(1'b1);
  endtask
  task automatic wb(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) wbit(b[i], r);
    wbit(1'b1, r);
    ack = !r;
  endtask
  task automatic rb(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      wbit(1'b1, r);
      b[i] = r;
    end
    wbit(!ack, r);
  endtask
endmodule

/* cra_pkg.sv */
// Purpose: types shared by the call ram / config rom block
// Assumes: cra_regs.svh supplies the numbers
// Notes: configuration struct mirrors rom bytes 0 and 1
package cra_pkg;

  // serial slave states, gray along address, sub-address and write paths and between RDAT and RACK; AACK to RDAT changes three bits
  typedef enum logic [3:0] {
    CRA_IDLE = 4'h0,
    CRA_ADDR = 4'h1,
    CRA_AACK = 4'h3,
    CRA_SUB = 4'h2,
    CRA_SACK = 4'h6,
    CRA_WDAT = 4'h7,
    CRA_WACK = 4'h5,
    CRA_RDAT = 4'h4,
    CRA_RACK = 4'hC
  } cra_state_e;

  // decoded configuration bytes 0 and 1
  typedef struct packed {
    logic alt_protocol;
    logic long_cycle;
    logic [3:0] batch_number;
    logic continuous_decode;
    logic invert_data;
    logic [1:0] rx_estab_sel;
    logic [1:0] osc_estab_sel;
    logic [1:0] bit_rate_sel;
    logic synth_enable;
    logic converter_enable;
  } cra_cfg_s;

  // one received call byte from the decoding path
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } cra_call_s;

endpackage

/* cra_regs.svh */
// Purpose: register offsets, field positions and timing counts for the call ram / config rom block
// Assumes: core clock of 4 ns
// Notes: definitions only
`ifndef CRA_REGS_SVH
`define CRA_REGS_SVH

// serial bus sub-addresses
`define CRA_OFS_WPTR 8'h06
`define CRA_OFS_EEPTR 8'h07
`define CRA_OFS_RPTR 8'h08
`define CRA_OFS_RAMDAT 8'h09
`define CRA_OFS_EEDAT 8'h0A
`define CRA_UNMAPPED_RD 8'hFF

// call ram geometry
`define CRA_RAM_DEPTH 96
`define CRA_RAM_LAST 7'h5F
`define CRA_PTR_ZERO 7'h00

// config rom geometry
`define CRA_ROM_BYTES 48
`define CRA_ROM_COLS 6
`define CRA_COL_LAST 3'h5
`define CRA_ROW_LAST 3'h7
`define CRA_COL_LO 0
`define CRA_COL_HI 2
`define CRA_ROW_LO 3
`define CRA_ROW_HI 5

// programming cycle: 7.5 ms longest, rounded down to cycles
`define CRA_PROG_TIME_NS 7500000
`define CRA_CLK_PERIOD_NS 4

// serial bus framing
`define CRA_BITS_PER_BYTE 4'h8
`define CRA_LAST_BIT 4'h7

// fifo in front of the ram
`define CRA_FIFO_DEPTH 32

`endif
